/* File: hw/socb_option_config.sv */
// APB register bank for the system option bits and the controls they drive.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module socb_option_config
    import socb_pkg::*;
#(
    parameter int TB_DIVIDE = SOCB_TB_DIVIDE
) (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SOCB_ADDR_WIDTH-1:0] paddr,
    input wire logic [SOCB_DATA_WIDTH-1:0] pwdata,
    output logic [SOCB_DATA_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Chip state and clock sources.
    input wire logic stop_mode,
    input wire logic internal_clock_in,
    input wire logic external_clock_in,
    input wire logic timebase_tick_in,
    // Clock generator controls.
    output logic xtal_slow_range,
    output logic monitor_expect_slow,
    output logic clock_gen_run,
    output logic internal_clock_out,
    output logic external_clock_out,
    // Pin controls.
    output logic osc_input_clock_mode,
    output logic osc_pins_gpio_mode,
    output logic select_pullup_enable,
    // Timebase, watchdog and voltage monitor controls.
    output logic timebase_tick_out,
    output logic [SOCB_WDOG_WIDTH-1:0] watchdog_timeout_cycles,
    output logic low_voltage_detector_enable
);

    // Stored option bits and the write-once lock.
    socb_cfg_type cfg;
    logic locked;

    // Bus slave state.
    socb_bus_state_type bus_state;
    socb_bus_state_type next_bus_state;

    // Combinational helpers.
    logic setup_phase;
    logic bus_commit;
    logic cfg_write;
    logic next_clock_gen_run;
    logic next_vmon_enable;
    logic [SOCB_DATA_WIDTH-1:0] next_prdata;
    logic next_pslverr;

    // Word address decode, shared by read data and error logic.
    function automatic logic is_offset(
        input logic [SOCB_ADDR_WIDTH-1:0] addr,
        input logic [SOCB_ADDR_WIDTH-1:0] offset
    );
        is_offset = (addr[SOCB_ADDR_WIDTH-1:2] == offset[SOCB_ADDR_WIDTH-1:2]);
    endfunction

    // Detector is wanted when the chip runs, or in stop when allowed.
    function automatic logic vmon_on(
        input socb_cfg_type c,
        input logic in_stop
    );
        vmon_on = !in_stop ||
                  (c.voltage_monitor_in_stop && !c.voltage_monitor_powerdown);
    endfunction

    // A request is taken in setup; it completes at the edge after.
    assign setup_phase = psel && !penable && bus_state == SOCB_IDLE;
    assign bus_commit = psel && penable && pready;
    assign cfg_write = bus_commit && pwrite && !pslverr &&
                       is_offset(paddr, SOCB_CONFIG_OFFSET);

    // Phase sequencing: one cycle of setup, one cycle of access.
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            SOCB_IDLE: begin
                if (setup_phase) begin
                    next_bus_state = SOCB_ACCESS;
                end
            end
            SOCB_ACCESS: begin
                next_bus_state = SOCB_DONE;
            end
            SOCB_DONE: begin
                next_bus_state = (psel && !penable) ? SOCB_ACCESS
                                                    : SOCB_IDLE;
            end
            default: begin
                next_bus_state = SOCB_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state <= SOCB_IDLE;
        end else if (ce) begin
            bus_state <= next_bus_state;
        end
    end

    // Read data and error are worked out from the setup phase request.
    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        if (is_offset(paddr, SOCB_CONFIG_OFFSET)) begin
            next_prdata[SOCB_CFG_WIDTH-1:0] = cfg;
            next_pslverr = pwrite && locked;
        end else if (is_offset(paddr, SOCB_STATUS_OFFSET)) begin
            next_prdata[SOCB_ST_LOCKED_BIT] = locked;
            next_prdata[SOCB_ST_STOP_BIT] = stop_mode;
            next_prdata[SOCB_ST_CLK_RUN_BIT] = clock_gen_run;
            next_prdata[SOCB_ST_VMON_BIT] = low_voltage_detector_enable;
            next_prdata[SOCB_ST_PIN_CLK_BIT] = osc_input_clock_mode;
            next_prdata[SOCB_ST_PULLUP_BIT] = select_pullup_enable;
            next_pslverr = pwrite;
        end else if (is_offset(paddr, SOCB_WDOG_OFFSET)) begin
            next_prdata[SOCB_WDOG_WIDTH-1:0] = watchdog_timeout_cycles;
            next_pslverr = pwrite;
        end else begin
            next_pslverr = 1'b1;
        end
    end

    // The answer is registered so the port comes from flip-flops; this
    // adds no wait state, as pready rises at the end of setup, and keeps timing clean.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= next_bus_state == SOCB_ACCESS;
            if (next_bus_state == SOCB_ACCESS) begin
                pslverr <= next_pslverr;
                prdata <= pwrite ? '0 : next_prdata;
            end else begin
                pslverr <= 1'b0;
                prdata <= '0;
            end
        end
    end

    // Option bits: reset clears all of them, the first write stores them
    // and locks them, so a runaway program cannot change the clock or
    // watchdog setup afterwards.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= SOCB_CONFIG_RESET;
            locked <= 1'b0;
        end else if (ce && cfg_write) begin
            cfg <= pwdata[SOCB_CFG_WIDTH-1:0];
            locked <= 1'b1;
        end
    end

    // Crystal range and clock monitor expectation follow one bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_slow_range <= 1'b0;
            monitor_expect_slow <= 1'b0;
        end else if (ce) begin
            xtal_slow_range <= cfg.slow_crystal_select;
            monitor_expect_slow <= cfg.slow_crystal_select;
        end
    end

    // Oscillator pins: clock input, or both pins left to the port logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_input_clock_mode <= 1'b0;
            osc_pins_gpio_mode <= 1'b1;
        end else if (ce) begin
            osc_input_clock_mode <= cfg.external_clock_pin_enable;
            osc_pins_gpio_mode <= !cfg.external_clock_pin_enable;
        end
    end

    // Clock generation stays on outside stop, and in stop only if allowed.
    assign next_clock_gen_run = !stop_mode || cfg.osc_run_in_stop;

    // Gated clocks are forced low while generation is halted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_gen_run <= 1'b0;
            internal_clock_out <= 1'b0;
            external_clock_out <= 1'b0;
        end else if (ce) begin
            clock_gen_run <= next_clock_gen_run;
            internal_clock_out <= next_clock_gen_run && internal_clock_in;
            external_clock_out <= next_clock_gen_run && external_clock_in &&
                                  cfg.external_clock_pin_enable;
        end
    end

    // Pullup on the slave-select pin is the inverse of the disable bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_pullup_enable <= 1'b1;
        end else if (ce) begin
            select_pullup_enable <= !cfg.select_pullup_disable;
        end
    end

    // Watchdog period; the long period applies out of reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_timeout_cycles <= SOCB_WDOG_LONG;
        end else if (ce) begin
            watchdog_timeout_cycles <= cfg.watchdog_rate_select ?
                SOCB_WDOG_SHORT : SOCB_WDOG_LONG;
        end
    end

    // Low-voltage detector enable.
    assign next_vmon_enable = vmon_on(cfg, stop_mode);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_detector_enable <= 1'b1;
        end else if (ce) begin
            low_voltage_detector_enable <= next_vmon_enable;
        end
    end

    // Timebase path with the optional divider.
    socb_timebase_prescale #(
        .DIVIDE(TB_DIVIDE)
    ) u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .prescale_select(cfg.timebase_prescale_select),
        .tick_in(timebase_tick_in),
        .tick_out(timebase_tick_out)
    );

    // Checks on the controls against the stored bits.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_xtal_range;
        ce |=> xtal_slow_range == $past(cfg.slow_crystal_select);
    endproperty
    a_xtal_range: assert property (p_xtal_range)
        else $error("Crystal range does not follow the slow select bit.");

    property p_monitor;
        xtal_slow_range == monitor_expect_slow;
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("Monitor expectation differs from crystal range.");

    property p_pin_clock;
        ce && cfg.external_clock_pin_enable |=>
            osc_input_clock_mode && !osc_pins_gpio_mode;
    endproperty
    a_pin_clock: assert property (p_pin_clock)
        else $error("Oscillator pin did not become a clock input.");

    property p_pin_gpio;
        ce && !cfg.external_clock_pin_enable |=>
            !osc_input_clock_mode && osc_pins_gpio_mode;
    endproperty
    a_pin_gpio: assert property (p_pin_gpio)
        else $error("Oscillator pins did not return to port use.");

    property p_stop_run;
        ce && stop_mode && cfg.osc_run_in_stop |=>
            clock_gen_run && internal_clock_out == $past(internal_clock_in);
    endproperty
    a_stop_run: assert property (p_stop_run)
        else $error("Clock generation halted although allowed in stop.");

    property p_stop_halt;
        ce && stop_mode && !cfg.osc_run_in_stop |=>
            !clock_gen_run && !internal_clock_out && !external_clock_out;
    endproperty
    a_stop_halt: assert property (p_stop_halt)
        else $error("Clocks not forced low in stop mode.");

    property p_pullup;
        ce |=> select_pullup_enable != $past(cfg.select_pullup_disable);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("Select pin pullup does not match its disable bit.");

    property p_wdog;
        ce && cfg.watchdog_rate_select |=>
            watchdog_timeout_cycles == SOCB_WDOG_SHORT;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("Short watchdog period not selected.");

    property p_wdog_reset;
        $rose(presetn) |-> !cfg.watchdog_rate_select &&
            watchdog_timeout_cycles == SOCB_WDOG_LONG;
    endproperty
    a_wdog_reset: assert property (p_wdog_reset)
        else $error("Watchdog rate not cleared by reset.");

    property p_vmon_stop;
        ce && stop_mode |=> low_voltage_detector_enable ==
            ($past(cfg.voltage_monitor_in_stop) &&
             !$past(cfg.voltage_monitor_powerdown));
    endproperty
    a_vmon_stop: assert property (p_vmon_stop)
        else $error("Detector stop-mode enable is wrong.");

    property p_locked_hold;
        locked |=> $stable(cfg);
    endproperty
    a_locked_hold: assert property (p_locked_hold)
        else $error("Option bits changed after they were locked.");

    property p_write_store;
        ce && cfg_write && !locked |=>
            cfg == $past(pwdata[SOCB_CFG_WIDTH-1:0]) && locked;
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("First write did not store and lock the options.");

endmodule

/* File: hw/socb_pkg.sv */
// Package with constants and types for the system option configuration bits.
package socb_pkg;

    // Register byte offsets on the APB port.
    localparam logic [7:0] SOCB_CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] SOCB_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SOCB_WDOG_OFFSET = 8'h08;
    localparam int SOCB_ADDR_WIDTH = 8;
    localparam int SOCB_DATA_WIDTH = 32;

    // Field positions inside the configuration word.
    localparam int SOCB_SLOW_XTAL_BIT = 0;
    localparam int SOCB_EXT_CLK_PIN_BIT = 1;
    localparam int SOCB_TB_PRESCALE_BIT = 2;
    localparam int SOCB_OSC_RUN_STOP_BIT = 3;
    localparam int SOCB_PULLUP_DIS_BIT = 4;
    localparam int SOCB_WDOG_RATE_BIT = 5;
    localparam int SOCB_VMON_STOP_BIT = 6;
    localparam int SOCB_VMON_PWRD_BIT = 7;
    localparam int SOCB_CFG_WIDTH = 8;

    // Field positions inside the status word.
    localparam int SOCB_ST_LOCKED_BIT = 0;
    localparam int SOCB_ST_STOP_BIT = 1;
    localparam int SOCB_ST_CLK_RUN_BIT = 2;
    localparam int SOCB_ST_VMON_BIT = 3;
    localparam int SOCB_ST_PIN_CLK_BIT = 4;
    localparam int SOCB_ST_PULLUP_BIT = 5;

    // Reset value: every option clear, including the watchdog rate.
    localparam logic [7:0] SOCB_CONFIG_RESET = 8'h00;

    // Watchdog timeout counts in reference clock cycles.
    localparam int SOCB_WDOG_WIDTH = 18;
    localparam logic [17:0] SOCB_WDOG_SHORT = 18'h0_1ff0;
    localparam logic [17:0] SOCB_WDOG_LONG = 18'h3_fff0;

    // Timebase extra prescaler ratio.
    localparam int SOCB_TB_DIVIDE = 128;

    // Stored option bits, most significant field first.
    typedef struct packed {
        logic voltage_monitor_powerdown;
        logic voltage_monitor_in_stop;
        logic watchdog_rate_select;
        logic select_pullup_disable;
        logic osc_run_in_stop;
        logic timebase_prescale_select;
        logic external_clock_pin_enable;
        logic slow_crystal_select;
    } socb_cfg_type;

    // Bus slave phase states.
    typedef enum logic [2:0] {
        SOCB_IDLE = 3'b001,
        SOCB_ACCESS = 3'b010,
        SOCB_DONE = 3'b100
    } socb_bus_state_type;

endpackage

/* File: hw/socb_timebase_prescale.sv */
// Optional divide-by-DIVIDE stage (128 by default) in the timebase tick path.
`timescale 1ns/1ps
module socb_timebase_prescale
    import socb_pkg::*;
#(
    parameter int DIVIDE = SOCB_TB_DIVIDE
) (
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Tick path.
    input wire logic prescale_select,
    input wire logic tick_in,
    output logic tick_out
);

    localparam int CW = $clog2(DIVIDE);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic [CW-1:0] count;

    // Count input ticks only while the prescaler is in the path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (ce) begin
            if (!prescale_select) begin
                count <= '0;
            end else if (tick_in) begin
                count <= (count == LAST) ? '0 : count + 1'b1;
            end
        end
    end

    // Bypass passes each tick; otherwise one tick per DIVIDE input ticks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_out <= 1'b0;
        end else if (ce) begin
            tick_out <= prescale_select ? (tick_in && count == LAST)
                                        : tick_in;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_bypass;
        ce && !prescale_select |=> tick_out == $past(tick_in);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Bypassed tick did not pass straight through.");

    property p_divided;
        ce && prescale_select && tick_in && count != LAST |=> !tick_out;
    endproperty
    a_divided: assert property (p_divided)
        else $error("Prescaled tick fired before the count ended.");

endmodule

/* File: verif/tb_top.sv */
// Self-checking testbench for the system option configuration bank.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb_top
    import socb_pkg::*;
;
    localparam int TBDIV = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic stop_mode = 1'b0;
    logic internal_clock_in = 1'b0;
    logic external_clock_in = 1'b0;
    logic timebase_tick_in = 1'b0;
    logic xtal_slow_range, monitor_expect_slow, clock_gen_run;
    logic internal_clock_out, external_clock_out;
    logic osc_input_clock_mode, osc_pins_gpio_mode, select_pullup_enable;
    logic timebase_tick_out, low_voltage_detector_enable;
    logic [17:0] watchdog_timeout_cycles;
    int num_errors = 0;
    int total_checks = 0;
    int tick_count = 0;
    bit counting = 0;
    logic [31:0] seed = 32'h0000_5681;
    logic [31:0] rd;
    logic err;
    logic [7:0] cfg;

    // A 4 ns period gives the 250 MHz bus clock.
    always #2 pclk = ~pclk;

    // A small divide ratio keeps the prescaler test short.
    socb_option_config #(.TB_DIVIDE(TBDIV)) uut (
        .pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_mode(stop_mode),
        .internal_clock_in(internal_clock_in),
        .external_clock_in(external_clock_in),
        .timebase_tick_in(timebase_tick_in),
        .xtal_slow_range(xtal_slow_range),
        .monitor_expect_slow(monitor_expect_slow),
        .clock_gen_run(clock_gen_run),
        .internal_clock_out(internal_clock_out),
        .external_clock_out(external_clock_out),
        .osc_input_clock_mode(osc_input_clock_mode),
        .osc_pins_gpio_mode(osc_pins_gpio_mode),
        .select_pullup_enable(select_pullup_enable),
        .timebase_tick_out(timebase_tick_out),
        .watchdog_timeout_cycles(watchdog_timeout_cycles),
        .low_voltage_detector_enable(low_voltage_detector_enable)
    );

    // Counts output ticks only inside a measuring window.
    always @(posedge pclk) begin
        if (counting && timebase_tick_out === 1'b1) begin
            tick_count++;
        end
    end

    // Xorshift generator; the seed is fixed so every run repeats.
    function automatic logic [31:0] xrand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Clock generation runs outside stop or when kept alive by the option.
    function automatic logic exp_run(input logic [7:0] c, input logic s);
        return !s || c[3];
    endfunction

    // The detector is always on outside stop mode.
    function automatic logic exp_lvd(input logic [7:0] c, input logic s);
        return !s || (c[6] && !c[7]);
    endfunction

    function automatic logic [17:0] exp_wdog(input logic [7:0] c);
        return c[5] ? 18'h0_1ff0 : 18'h3_fff0;
    endfunction

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench watchdog ends a wait that never sees pready.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never re-drives psel now.
        @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // Compares every control output except timebase_tick_out against values derived from the bits.
    task automatic check_outputs(input logic [7:0] c);
        logic s, ic, ec, r;
        s = stop_mode;
        ic = internal_clock_in;
        ec = external_clock_in;
        r = exp_run(c, s);
        `CHK("xtal_slow_range", c[0], xtal_slow_range)
        `CHK("monitor_expect_slow", c[0], monitor_expect_slow)
        `CHK("osc_input_clock_mode", c[1], osc_input_clock_mode)
        `CHK("osc_pins_gpio_mode", !c[1], osc_pins_gpio_mode)
        `CHK("clock_gen_run", r, clock_gen_run)
        `CHK("int_clk_out", r && ic, internal_clock_out)
        `CHK("ext_clk_out", r && ec && c[1], external_clock_out)
        `CHK("select_pullup_enable", !c[4], select_pullup_enable)
        `CHK("watchdog_timeout", exp_wdog(c), watchdog_timeout_cycles)
        `CHK("detector", exp_lvd(c, s), low_voltage_detector_enable)
    endtask

    // Sends eight ticks and counts what leaves the timebase path.
    task automatic tick_burst(input logic [7:0] c);
        tick_count = 0;
        counting = 1;
        for (int k = 0; k < 8; k++) begin
            timebase_tick_in <= 1'b1;
            @(posedge pclk);
            timebase_tick_in <= 1'b0;
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
        counting = 0;
        `CHK("tick_count", c[2] ? 8 / TBDIV : 8, tick_count)
    endtask

    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog for a hung handshake; the tests need well under this span.
    initial begin
        #100000;
        num_errors++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check_outputs(8'h00);
        apb(1'b0, SOCB_WDOG_OFFSET, 32'h0000_0000);
        `CHK("wdog_reg", 32'h0003_fff0, rd)
        apb(1'b0, 8'h0c, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, err)
        apb(1'b1, SOCB_STATUS_OFFSET, 32'h0000_00ff);
        `CHK("status_write_err", 1'b1, err)
        // Corner values first, then random option patterns.
        for (int i = 0; i < 12; i++) begin
            cfg = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'(xrand());
            do_reset();
            // Outputs settle one edge after release; look one edge later.
            @(posedge pclk);
            check_outputs(8'h00);
            apb(1'b1, SOCB_CONFIG_OFFSET, {24'h00_0000, cfg});
            `CHK("config_write_err", 1'b0, err)
            apb(1'b1, SOCB_CONFIG_OFFSET, {24'h00_0000, ~cfg});
            `CHK("second_write_err", 1'b1, err)
            apb(1'b0, SOCB_CONFIG_OFFSET, 32'h0000_0000);
            `CHK("config_read", {24'h00_0000, cfg}, rd)
            for (int s = 0; s < 2; s++) begin
                stop_mode <= s[0];
                internal_clock_in <= 1'(xrand());
                external_clock_in <= 1'(xrand());
                repeat (3) @(posedge pclk);
                check_outputs(cfg);
            end
            // A low clock enable must freeze the stop-mode controls.
            ce <= 1'b0;
            stop_mode <= 1'b0;
            repeat (3) @(posedge pclk);
            `CHK("ce_run", exp_run(cfg, 1'b1), clock_gen_run)
            `CHK("ce_lvd", exp_lvd(cfg, 1'b1), low_voltage_detector_enable)
            ce <= 1'b1;
            tick_burst(cfg);
            apb(1'b0, SOCB_STATUS_OFFSET, 32'h0000_0000);
            `CHK("status", {26'h000_0000, !cfg[4], cfg[1], 4'hd}, rd)
        end
        conclude();
    end
endmodule
